// [include/dcd_pkg.sv]
`default_nettype none
package dcd_pkg;

  // array shape of the default part
  localparam int BANK_W = 3;
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;

  // address bit roles during read and write
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // {chip select, row strobe, column strobe, write enable}, all active low
  localparam logic [3:0] PAT_MODE_SET = 4'h0;
  localparam logic [3:0] PAT_REFRESH  = 4'h1;
  localparam logic [3:0] PAT_PRECH    = 4'h2;
  localparam logic [3:0] PAT_ACTIVATE = 4'h3;
  localparam logic [3:0] PAT_WRITE    = 4'h4;
  localparam logic [3:0] PAT_READ     = 4'h5;
  localparam logic [3:0] PAT_ZQ       = 4'h6;
  localparam logic [3:0] PAT_NOP      = 4'h7;

  // burst occupancy in clock cycles (two beats per clock)
  localparam logic [2:0] BURST_FULL_CYC = 3'h4;
  localparam logic [2:0] BURST_CHOP_CYC = 3'h2;
  localparam logic [2:0] BURST_NONE     = 3'h0;
  localparam logic [2:0] BURST_LAST     = 3'h1;
  localparam logic [2:0] BURST_STEP     = 3'h1;

  // reset values
  localparam logic RST_LOW = 1'h0;

  typedef enum logic [4:0] {
    CMD_NONE,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_SELFREFRESH_ENTRY,
    CMD_SELFREFRESH_EXIT,
    CMD_PRECHARGE,
    CMD_PRECHARGE_ALL,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_READ,
    CMD_NOP,
    CMD_DESELECT,
    CMD_POWERDOWN_ENTRY,
    CMD_POWERDOWN_EXIT,
    CMD_ZQ_LONG,
    CMD_ZQ_SHORT,
    CMD_ILLEGAL
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PDOWN,
    ST_SREF
  } dcd_state_t;

endpackage
`default_nettype wire

// [rtl/dcd_cmd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module dcd_cmd_decoder #(
  parameter int BANK_W = dcd_pkg::BANK_W,
  parameter int ROW_W  = dcd_pkg::ROW_W,
  parameter int COL_W  = dcd_pkg::COL_W
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  // command pins, active low strobes
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic [BANK_W-1:0] i_ba,
  input  wire logic [ROW_W-1:0]  i_addr,
  input  wire logic              i_odt,
  // burst configuration
  input  wire logic              i_otf_en,
  input  wire logic              i_fixed_chop,
  // decoded command
  output var  dcd_pkg::dcd_cmd_t o_cmd,
  output logic [BANK_W-1:0]      o_bank,
  output logic [ROW_W-1:0]       o_row,
  output logic [COL_W-1:0]       o_col,
  output logic                   o_ignored,
  // mode register access
  output logic [BANK_W-1:0]      o_mr_sel,
  output logic [ROW_W-1:0]       o_mr_op,
  // burst state
  output logic                   o_burst_busy,
  output logic                   o_chop,
  output logic                   o_auto_pre,
  output logic [BANK_W-1:0]      o_burst_bank,
  output logic                   o_autopre_stb,
  // power state and termination
  output logic                   o_pdown,
  output logic                   o_sref,
  output logic                   o_odt_en
);

  localparam int PIN_W = 6 + BANK_W + ROW_W;

  logic [PIN_W-1:0]    pins_s1_q;
  logic [PIN_W-1:0]    pins_s2_q;
  logic                cke_prev_q;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  dcd_pkg::dcd_state_t state_q;
  dcd_pkg::dcd_state_t state_d;
  dcd_pkg::dcd_cmd_t   steady_cmd;
  dcd_pkg::dcd_cmd_t   fall_cmd;
  dcd_pkg::dcd_cmd_t   cmd_d;

  // pins come from another chip: two flops before any decode
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
    end else begin
      pins_s1_q <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_odt, i_ba, i_addr};
      pins_s2_q <= pins_s1_q;
    end
  end

  wire              cke_now = pins_s2_q[PIN_W-1];
  wire [3:0]        pat     = pins_s2_q[PIN_W-2 -: 4];
  wire              odt_s   = pins_s2_q[BANK_W+ROW_W];
  wire [BANK_W-1:0] ba_s    = pins_s2_q[ROW_W +: BANK_W];
  wire [ROW_W-1:0]  a_s     = pins_s2_q[ROW_W-1:0];

  // odt is deliberately absent from every decode term below
  wire desel    = pat[3];
  wire nop_like = desel | (pat == dcd_pkg::PAT_NOP);
  wire steady   = cke_prev_q & cke_now;
  wire falling  = cke_prev_q & ~cke_now;
  wire burst_on = (cnt_q != dcd_pkg::BURST_NONE);
  wire idle     = (state_q == dcd_pkg::ST_IDLE) & ~burst_on;
  wire ap_bit   = a_s[dcd_pkg::AP_BIT];
  wire bc_bit   = a_s[dcd_pkg::BC_BIT];
  wire live_cmd = steady & (state_q == dcd_pkg::ST_IDLE) & ~desel;

  assign steady_cmd =
    desel                          ? dcd_pkg::CMD_DESELECT :
    (pat == dcd_pkg::PAT_MODE_SET) ? dcd_pkg::CMD_MODE_SET :
    (pat == dcd_pkg::PAT_REFRESH)  ? dcd_pkg::CMD_REFRESH :
    (pat == dcd_pkg::PAT_PRECH)    ? (ap_bit ? dcd_pkg::CMD_PRECHARGE_ALL : dcd_pkg::CMD_PRECHARGE) :
    (pat == dcd_pkg::PAT_ACTIVATE) ? dcd_pkg::CMD_ACTIVATE :
    (pat == dcd_pkg::PAT_WRITE)    ? dcd_pkg::CMD_WRITE :
    (pat == dcd_pkg::PAT_READ)     ? dcd_pkg::CMD_READ :
    (pat == dcd_pkg::PAT_ZQ)       ? (ap_bit ? dcd_pkg::CMD_ZQ_LONG : dcd_pkg::CMD_ZQ_SHORT) :
                                     dcd_pkg::CMD_NOP;

  // self refresh only from all-idle; power-down entry during a burst decodes as illegal
  assign fall_cmd =
    (!desel && pat == dcd_pkg::PAT_REFRESH && idle) ? dcd_pkg::CMD_SELFREFRESH_ENTRY :
    (nop_like && !burst_on)                         ? dcd_pkg::CMD_POWERDOWN_ENTRY :
                                                      dcd_pkg::CMD_ILLEGAL;

  // refresh decodes only with steady clock enable, so never in power-down
  assign cmd_d =
    (state_q == dcd_pkg::ST_SREF)  ? (cke_now ? dcd_pkg::CMD_SELFREFRESH_EXIT : dcd_pkg::CMD_NONE) :
    (state_q == dcd_pkg::ST_PDOWN) ? (!cke_now ? dcd_pkg::CMD_NONE :
                                      nop_like ? dcd_pkg::CMD_POWERDOWN_EXIT :
                                                 dcd_pkg::CMD_ILLEGAL) :
    steady                         ? steady_cmd :
    falling                        ? fall_cmd :
                                     dcd_pkg::CMD_NONE;

  wire is_rw    = (cmd_d == dcd_pkg::CMD_WRITE) | (cmd_d == dcd_pkg::CMD_READ);
  // a second read or write inside a burst is dropped, never cuts it short
  wire rw_start = is_rw & ~burst_on;
  wire ignored  = (is_rw & burst_on) | (cmd_d == dcd_pkg::CMD_ILLEGAL);
  wire chop_d   = i_otf_en ? ~bc_bit : i_fixed_chop;
  wire is_mrs   = (cmd_d == dcd_pkg::CMD_MODE_SET);
  wire take_adr = rw_start | is_mrs | (cmd_d == dcd_pkg::CMD_ACTIVATE)
                | (cmd_d == dcd_pkg::CMD_PRECHARGE) | (cmd_d == dcd_pkg::CMD_PRECHARGE_ALL);
  wire burst_end = (cnt_q == dcd_pkg::BURST_LAST);

  // nop and deselect do not stop the count; it steps down once per cycle
  assign cnt_d = rw_start ? (chop_d ? dcd_pkg::BURST_CHOP_CYC : dcd_pkg::BURST_FULL_CYC) :
                 burst_on ? (cnt_q - dcd_pkg::BURST_STEP) : dcd_pkg::BURST_NONE;

  always_comb begin
    state_d = state_q;
    case (state_q)
      dcd_pkg::ST_IDLE: begin
        if (cmd_d == dcd_pkg::CMD_SELFREFRESH_ENTRY) begin
          state_d = dcd_pkg::ST_SREF;
        end else if (cmd_d == dcd_pkg::CMD_POWERDOWN_ENTRY) begin
          state_d = dcd_pkg::ST_PDOWN;
        end
      end
      dcd_pkg::ST_PDOWN: begin
        if (cmd_d == dcd_pkg::CMD_POWERDOWN_EXIT) begin
          state_d = dcd_pkg::ST_IDLE;
        end
      end
      dcd_pkg::ST_SREF: begin
        if (cmd_d == dcd_pkg::CMD_SELFREFRESH_EXIT) begin
          state_d = dcd_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = dcd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cke_prev_q <= dcd_pkg::RST_LOW;
      state_q    <= dcd_pkg::ST_IDLE;
      cnt_q      <= dcd_pkg::BURST_NONE;
      o_cmd      <= dcd_pkg::CMD_NONE;
      o_ignored  <= dcd_pkg::RST_LOW;
    end else begin
      cke_prev_q <= cke_now;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      o_cmd      <= cmd_d;
      o_ignored  <= ignored;
    end
  end

  // address and mode register capture
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bank   <= '0;
      o_row    <= '0;
      o_col    <= '0;
      o_mr_sel <= '0;
      o_mr_op  <= '0;
    end else begin
      if (take_adr) begin
        o_bank <= ba_s;
        o_row  <= a_s;
        o_col  <= a_s[COL_W-1:0];
      end
      if (is_mrs) begin
        o_mr_sel <= ba_s;
        o_mr_op  <= a_s;
      end
    end
  end

  // burst state; auto precharge fires as the last cycle retires
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_burst_busy  <= dcd_pkg::RST_LOW;
      o_chop        <= dcd_pkg::RST_LOW;
      o_auto_pre    <= dcd_pkg::RST_LOW;
      o_burst_bank  <= '0;
      o_autopre_stb <= dcd_pkg::RST_LOW;
    end else begin
      o_burst_busy  <= (cnt_d != dcd_pkg::BURST_NONE);
      o_autopre_stb <= burst_end & o_auto_pre;
      if (rw_start) begin
        o_chop       <= chop_d;
        o_auto_pre   <= ap_bit;
        o_burst_bank <= ba_s;
      end
    end
  end

  // power state flags and termination enable
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pdown  <= dcd_pkg::RST_LOW;
      o_sref   <= dcd_pkg::RST_LOW;
      o_odt_en <= dcd_pkg::RST_LOW;
    end else begin
      o_pdown  <= (state_d == dcd_pkg::ST_PDOWN);
      o_sref   <= (state_d == dcd_pkg::ST_SREF);
      o_odt_en <= odt_s & (state_d != dcd_pkg::ST_SREF);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  desel_as_nop_a: assert property (steady && desel && state_q == dcd_pkg::ST_IDLE
    |=> o_cmd == dcd_pkg::CMD_DESELECT && o_burst_busy == $past(cnt_d != dcd_pkg::BURST_NONE))
    else $error("deselect not decoded as idle command");

  full_burst_a: assert property ($rose(o_burst_busy) && !o_chop
    |-> o_burst_busy [*4] ##1 !o_burst_busy)
    else $error("full burst did not last four cycles");

  chop_burst_a: assert property ($rose(o_burst_busy) && o_chop
    |-> o_burst_busy [*2] ##1 !o_burst_busy)
    else $error("chopped burst did not last two cycles");

  nop_keeps_a: assert property (cnt_q > dcd_pkg::BURST_LAST && nop_like && steady
    |=> o_burst_busy)
    else $error("no-operation ended a burst");

  autopre_end_a: assert property (o_autopre_stb
    |-> !o_burst_busy && $past(o_burst_busy) && $past(o_auto_pre))
    else $error("auto precharge strobe off the burst end");

  odt_sref_a: assert property (o_sref |-> !o_odt_en)
    else $error("termination enabled in self refresh");

  pd_no_ref_a: assert property (o_pdown |-> o_cmd != dcd_pkg::CMD_REFRESH)
    else $error("refresh decoded in power-down");

  sref_entry_a: assert property (falling && idle && !desel && pat == dcd_pkg::PAT_REFRESH
    |=> o_sref ##1 o_sref)
    else $error("self refresh not entered");

  sref_exit_a: assert property (o_sref && cke_now |=> !o_sref
    && o_cmd == dcd_pkg::CMD_SELFREFRESH_EXIT)
    else $error("self refresh exit missed");

  write_ap_a: assert property (rw_start && steady_cmd == dcd_pkg::CMD_WRITE
    |=> o_cmd == dcd_pkg::CMD_WRITE && o_auto_pre == $past(ap_bit))
    else $error("write precharge flag wrong");

  pd_exit_a: assert property (o_pdown && cke_now && nop_like
    |=> !o_pdown && o_cmd == dcd_pkg::CMD_POWERDOWN_EXIT)
    else $error("power-down exit missed");

  read_ap_a: assert property (rw_start && steady_cmd == dcd_pkg::CMD_READ
    |=> o_cmd == dcd_pkg::CMD_READ && o_auto_pre == $past(ap_bit))
    else $error("read precharge flag wrong");

  refuse_rw_a: assert property (is_rw && burst_on
    |=> o_ignored && $stable(o_burst_bank) && $stable(o_chop))
    else $error("read or write inside a burst not refused");

  mrs_capture_a: assert property (is_mrs
    |=> o_mr_sel == $past(ba_s) && o_mr_op == $past(a_s))
    else $error("mode register select or opcode not captured");

  rw_capture_a: assert property (rw_start
    |=> o_burst_bank == $past(ba_s) && o_bank == $past(ba_s) && o_row == $past(a_s))
    else $error("burst bank or address not captured");

  otf_chop_a: assert property (rw_start && i_otf_en
    |=> o_chop != $past(bc_bit))
    else $error("on-the-fly chop not taken from bit 12");

  fixed_chop_a: assert property (rw_start && !i_otf_en
    |=> o_chop == $past(i_fixed_chop))
    else $error("fixed burst length not applied");

  zq_decode_a: assert property (live_cmd && pat == dcd_pkg::PAT_ZQ
    |=> o_cmd == ($past(ap_bit) ? dcd_pkg::CMD_ZQ_LONG : dcd_pkg::CMD_ZQ_SHORT))
    else $error("calibration length decoded wrong");

  prech_decode_a: assert property (live_cmd && pat == dcd_pkg::PAT_PRECH
    |=> o_cmd == ($past(ap_bit) ? dcd_pkg::CMD_PRECHARGE_ALL : dcd_pkg::CMD_PRECHARGE))
    else $error("precharge scope decoded wrong");

  refresh_decode_a: assert property (live_cmd && pat == dcd_pkg::PAT_REFRESH
    |=> o_cmd == dcd_pkg::CMD_REFRESH)
    else $error("refresh not decoded");

  pd_hold_a: assert property (state_q == dcd_pkg::ST_PDOWN && !cke_now
    |=> o_pdown && o_cmd == dcd_pkg::CMD_NONE)
    else $error("power-down not held while clock enable low");

  pd_entry_a: assert property (falling && nop_like && !burst_on && state_q == dcd_pkg::ST_IDLE
    |=> o_pdown && o_cmd == dcd_pkg::CMD_POWERDOWN_ENTRY)
    else $error("power-down entry missed");

  burst_hold_a: assert property (o_burst_busy && $past(o_burst_busy)
    |-> $stable(o_burst_bank) && $stable(o_chop) && $stable(o_auto_pre))
    else $error("burst attributes changed mid-burst");

  odt_follow_a: assert property (!o_sref
    |-> o_odt_en == $past(odt_s))
    else $error("termination enable not following its input");

  cov_read_ap_c: cover property ($rose(o_burst_busy) ##[1:4] o_autopre_stb);
  cov_sref_c:    cover property ($rose(o_sref) ##[1:20] $fell(o_sref));
  cov_pdown_c:   cover property ($rose(o_pdown) ##[1:20] $fell(o_pdown));
  cov_refuse_c:  cover property (o_burst_busy && o_ignored);
  cov_illegal_c: cover property (o_cmd == dcd_pkg::CMD_ILLEGAL && o_ignored);

endmodule
`default_nettype wire

// [sim/dcd_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dcd_ctrl_model (
  // bench side
  input  wire logic        i_clk_sys,
  input  wire logic [3:0]  i_pat,
  input  wire logic        i_cke,
  input  wire logic [2:0]  i_ba,
  input  wire logic [13:0] i_addr,
  // command bus
  output logic             o_cke,
  output logic [3:0]       o_pins,
  output logic [2:0]       o_ba,
  output logic [13:0]      o_addr
);
  logic [16:0] last_q = 17'h0_0000;
  logic        flip_q = 1'h0;
  logic        sel;
  assign sel = !i_pat[3];
  // deselected lines are don't-care, so they wander instead of holding a stale value
  always_ff @(posedge i_clk_sys) begin
    flip_q <= !flip_q;
    if (sel) begin
      last_q <= {i_ba, i_addr};
    end
  end
  assign o_cke = i_cke;
  assign o_pins = sel ? i_pat : {1'b1, {3{flip_q}}};
  assign {o_ba, o_addr} = sel ? {i_ba, i_addr} : last_q ^ {17{flip_q}};
endmodule
`default_nettype wire

// [sim/dcd_cmd_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dcd_cmd_decoder_bench;
  logic               clk, rstn, otf, fchop, odt, ck;
  logic [3:0]         pat;
  logic [2:0]         ba;
  logic [13:0]        addr;
  wire logic          pcke;
  wire logic [3:0]    pins;
  wire logic [2:0]    pba;
  wire logic [13:0]   paddr;
  dcd_pkg::dcd_cmd_t  dcmd;
  logic [2:0]         bank, mr_sel, bbank;
  logic [13:0]        row, mr_op;
  logic [9:0]         col;
  logic               ign, busy, chop, ap, stb, pd, sr, odt_en;
  int                 n_fail = 0;
  int                 comparisons = 0;

  dcd_ctrl_model dcd_ctrl_model_inst (.i_clk_sys(clk), .i_pat(pat), .i_cke(ck), .i_ba(ba),
    .i_addr(addr), .o_cke(pcke), .o_pins(pins), .o_ba(pba), .o_addr(paddr));
  dcd_cmd_decoder dcd_cmd_decoder_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_cke(pcke),
    .i_cs_n(pins[3]), .i_ras_n(pins[2]), .i_cas_n(pins[1]), .i_we_n(pins[0]), .i_ba(pba),
    .i_addr(paddr), .i_odt(odt), .i_otf_en(otf), .i_fixed_chop(fchop), .o_cmd(dcmd),
    .o_bank(bank), .o_row(row), .o_col(col), .o_ignored(ign), .o_mr_sel(mr_sel),
    .o_mr_op(mr_op), .o_burst_busy(busy), .o_chop(chop), .o_auto_pre(ap),
    .o_burst_bank(bbank), .o_autopre_stb(stb), .o_pdown(pd), .o_sref(sr), .o_odt_en(odt_en));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_cmd(input dcd_pkg::dcd_cmd_t got, input dcd_pkg::dcd_cmd_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [3:0] p, input logic k, input logic [2:0] b, input logic [13:0] a);
    pat = p;
    ck = k;
    ba = b;
    addr = a;
  endtask

  // one command, then idle; the answer shows on the third rising edge after the pins are set
  task automatic cmd(input logic [3:0] p, input logic k, input logic [2:0] b, input logic [13:0] a,
                     input dcd_pkg::dcd_cmd_t e);
    @(negedge clk) put(p, k, b, a);
    @(negedge clk) put(dcd_pkg::PAT_NOP, k, 3'h0, 14'h0000);
    repeat (2) @(negedge clk);
    chk_cmd(dcmd, e);
  endtask

  task automatic t_table();
    cmd(dcd_pkg::PAT_MODE_SET, 1'b1, 3'h2, 14'h1234, dcd_pkg::CMD_MODE_SET);
    chk_vec({mr_sel, mr_op}, {3'h2, 14'h1234});
    cmd(dcd_pkg::PAT_REFRESH, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_REFRESH);
    cmd(dcd_pkg::PAT_PRECH, 1'b1, 3'h6, 14'h0000, dcd_pkg::CMD_PRECHARGE);
    chk_vec(bank, 3'h6);
    cmd(dcd_pkg::PAT_PRECH, 1'b1, 3'h0, 14'h0400, dcd_pkg::CMD_PRECHARGE_ALL);
    cmd(dcd_pkg::PAT_ACTIVATE, 1'b1, 3'h3, 14'h2abc, dcd_pkg::CMD_ACTIVATE);
    chk_vec({bank, row}, {3'h3, 14'h2abc});
    cmd(dcd_pkg::PAT_ZQ, 1'b1, 3'h0, 14'h0400, dcd_pkg::CMD_ZQ_LONG);
    cmd(dcd_pkg::PAT_ZQ, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_ZQ_SHORT);
    cmd(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_NOP);
    cmd(4'h8, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_DESELECT);
    cmd(dcd_pkg::PAT_ACTIVATE, 1'b0, 3'h0, 14'h0000, dcd_pkg::CMD_ILLEGAL);
    chk_vec(ign, 1'b1);
    cmd(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_NONE);
  endtask

  // a burst followed at once by a read, which must be refused while the burst runs
  task automatic burst(input logic [3:0] p, input logic o, input logic f, input logic a12,
                       input logic a10, input dcd_pkg::dcd_cmd_t e, input logic ch, input int n);
    otf = o;
    fchop = f;
    @(negedge clk) put(p, 1'b1, 3'h5, {1'b0, a12, 1'b0, a10, 10'h2a5});
    @(negedge clk) put(dcd_pkg::PAT_READ, 1'b1, 3'h1, 14'h0000);
    @(negedge clk) put(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000);
    @(negedge clk);
    chk_cmd(dcmd, e);
    chk_vec({busy, chop, ap, bbank, col}, {1'b1, ch, a10, 3'h5, 10'h2a5});
    @(negedge clk) chk_cmd(dcmd, dcd_pkg::CMD_READ);
    chk_vec(ign, 1'b1);
    repeat (n - 2) @(negedge clk);
    chk_vec(busy, 1'b1);
    @(negedge clk) chk_vec({busy, stb}, {1'b0, a10});
  endtask

  task automatic t_power();
    odt = 1'b1;
    cmd(dcd_pkg::PAT_NOP, 1'b0, 3'h0, 14'h0000, dcd_pkg::CMD_POWERDOWN_ENTRY);
    chk_vec({pd, odt_en}, 2'h3);
    @(negedge clk) put(dcd_pkg::PAT_REFRESH, 1'b0, 3'h0, 14'h0000);
    repeat (4) @(negedge clk);
    chk_vec({pd, sr}, 2'h2);
    cmd(4'hf, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_POWERDOWN_EXIT);
    chk_vec(pd, 1'b0);
    cmd(dcd_pkg::PAT_REFRESH, 1'b0, 3'h0, 14'h0000, dcd_pkg::CMD_SELFREFRESH_ENTRY);
    chk_vec({sr, odt_en}, 2'h2);
    cmd(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_SELFREFRESH_EXIT);
    chk_vec(sr, 1'b0);
    odt = 1'b0;
    repeat (512) @(negedge clk);
  endtask

  task automatic t_reset();
    @(negedge clk) put(dcd_pkg::PAT_WRITE, 1'b1, 3'h0, 14'h0000);
    @(negedge clk) put(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000);
    repeat (3) @(negedge clk);
    chk_vec(busy, 1'b1);
    rstn = 1'b0;
    #1 chk_vec(busy, 1'b0);
    chk_cmd(dcmd, dcd_pkg::CMD_NONE);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    cmd(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000, dcd_pkg::CMD_NOP);
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    otf = 1'b0;
    fchop = 1'b0;
    odt = 1'b0;
    put(dcd_pkg::PAT_NOP, 1'b1, 3'h0, 14'h0000);
    repeat (12) @(negedge clk);
    chk_cmd(dcmd, dcd_pkg::CMD_NONE);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_table();
    burst(dcd_pkg::PAT_WRITE, 1'b1, 1'b0, 1'b1, 1'b1, dcd_pkg::CMD_WRITE, 1'b0, 4);
    burst(dcd_pkg::PAT_READ, 1'b1, 1'b0, 1'b0, 1'b1, dcd_pkg::CMD_READ, 1'b1, 2);
    burst(dcd_pkg::PAT_WRITE, 1'b0, 1'b1, 1'b1, 1'b0, dcd_pkg::CMD_WRITE, 1'b1, 2);
    burst(dcd_pkg::PAT_READ, 1'b0, 1'b0, 1'b0, 1'b0, dcd_pkg::CMD_READ, 1'b0, 4);
    t_power();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
